// file: rtl/tfs_bit_phase.sv
// two-phase bit-rate tick generator from the reference clock
`timescale 1ns/10ps
module tfs_bit_phase (
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   output logic      o_ph_a,
   output logic      o_ph_b
);
   tfs_pkg::tfs_phase_st_t q;
   tfs_pkg::tfs_phase_st_t d;

   always_comb begin
      d = q;
      if (q.cnt == tfs_pkg::BIT_W'(tfs_pkg::BIT_DIV - 1)) begin
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + 8'h01;
      end
      // phases half a bit apart so a stepped count is stable when read
      d.ph_a = (d.cnt == '0);
      d.ph_b = (d.cnt == tfs_pkg::BIT_W'(tfs_pkg::BIT_HALF));
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_ph_a = q.ph_a;
   assign o_ph_b = q.ph_b;
endmodule

// file: rtl/tfs_mod_cnt.sv
// modulo-N counter stage with a wrap pulse for the next stage
`timescale 1ns/10ps
module tfs_mod_cnt #(
   parameter int W = 4,
   parameter int N = 10
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   input  wire logic         i_step,
   output logic [W-1:0]      o_count,
   output logic              o_wrap
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tfs_cnt_st_t;

   tfs_cnt_st_t q;
   tfs_cnt_st_t d;
   logic        last;

   assign last = (q.cnt == W'(N - 1));

   always_comb begin
      d = q;
      if (i_step) begin
         d.cnt = last ? '0 : q.cnt + W'(1);
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_count = q.cnt;
   assign o_wrap  = i_step & last;
endmodule

// file: rtl/tfs_pkg.sv
// shared constants and carrier types for the telemetry frame slot timer
package tfs_pkg;

   localparam int CLK_NS      = 100;
   localparam int CLK_HZ      = 10_000_000;
   localparam int BIT_HZ      = 72_000;
   // bit period truncates: 138 cycles, about 0.6 percent fast
   localparam int BIT_DIV     = CLK_HZ / BIT_HZ;
   localparam int BIT_HALF    = BIT_DIV / 2;
   localparam int BIT_W       = 8;

   localparam int BPW_N       = 10;
   localparam int BPW_W       = 4;
   localparam int GRP_N       = 2;
   localparam int GRP_W       = 1;
   localparam int CHAN_N      = 30;
   localparam int CHAN_W      = 5;
   localparam int FRAME_N     = 10;
   localparam int FRAME_W     = 4;
   localparam int MUX_N       = 3;
   localparam int MUX_W       = 2;

   localparam logic [BPW_W-1:0] BPW_SEQ_START = 4'h2;

   localparam int STEP_GAP_NS  = 1750;
   localparam int STEP_GAP_CYC = (STEP_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEQ_W        = 5;
   localparam logic [SEQ_W-1:0] SEQ_RELOAD = SEQ_W'(STEP_GAP_CYC - 1);

   localparam int MARK_NS      = 278_000;
   localparam int MARK_CYC     = MARK_NS / CLK_NS;
   localparam int MARK_W       = 12;
   localparam logic [MARK_W-1:0] MARK_LOAD = MARK_W'(MARK_CYC);

   localparam int N_STORE     = 10;
   localparam int N_MODE      = 3;
   localparam int N_SCAN      = GRP_N * MUX_N;
   localparam int GATE_W      = 3;
   localparam int MODE_CMD_W  = 2;

   typedef struct packed {
      logic [FRAME_W-1:0] frame;
      logic [MUX_W-1:0]   mux;
      logic [CHAN_W-1:0]  chan;
      logic               grp;
   } tfs_slot_t;

   typedef struct packed {
      logic      en;
      logic      frame_any;
      logic      mux_any;
      tfs_slot_t rd;
      tfs_slot_t wr;
   } tfs_patch_t;

   typedef tfs_patch_t [N_STORE-1:0] tfs_patch_arr_t;
   typedef logic [GATE_W-1:0] tfs_gate_t;
   typedef tfs_gate_t [N_MODE*N_SCAN-1:0] tfs_scan_tab_t;

   typedef enum logic [1:0] {TFS_MODE1, TFS_MODE2, TFS_MODE3} tfs_mode_t;
   typedef enum logic [1:0] {TFS_SEQ_IDLE, TFS_SEQ_READ, TFS_SEQ_WRITE}
      tfs_seq_t;

   typedef struct packed {
      logic [BIT_W-1:0] cnt;
      logic             ph_a;
      logic             ph_b;
   } tfs_phase_st_t;

   typedef struct packed {
      logic [MODE_CMD_W-1:0] mode_s1;
      logic [MODE_CMD_W-1:0] mode_s2;
      tfs_patch_arr_t        patch_s1;
      tfs_patch_arr_t        patch_s2;
      tfs_scan_tab_t         scan_s1;
      tfs_scan_tab_t         scan_s2;
      tfs_mode_t             mode;
      tfs_seq_t              seq;
      logic [SEQ_W-1:0]      seq_tmr;
      logic [MARK_W-1:0]     mark_a_tmr;
      logic [MARK_W-1:0]     mark_b_tmr;
      logic                  b_pend;
      logic                  bit_strobe;
      logic [BPW_W-1:0]      word_bit;
      logic                  sq_a;
      logic                  sq_b;
      logic                  mark_a;
      logic                  mark_b;
      logic [FRAME_W-1:0]    frame_stage;
      logic                  remote_sq;
      tfs_gate_t             scan_gate;
      logic                  psr_clear;
      logic [N_STORE-1:0]    rd;
      logic [N_STORE-1:0]    wr;
      logic                  enc_inh;
   } tfs_main_st_t;

endpackage

// file: rtl/tfs_slot_timer.sv
// telemetry frame slot timing: counter chain, slot strobes, sync waves
// How it works
// - phase A serialises, phase B steps word-bit count
// - word-bit wrap steps the group counter
// - group wrap steps the channel counter
// - channel wrap steps frame and multiplexer counters
// - group counter alternates the two interlaced groups
// - modulo-three counter shares slots among multiplexers
// - modulo-thirty channel counter tracks analog gates
// - modulo-ten frame counter tracks submultiplexer gates
// - decoded slots fire patched read/write strobes
// - scan order from group and multiplexer counts
// - three scan sequences, chosen by mode command
// - no command asserted selects sequence one
// - two sync sets, phase offset for interlace
// - group-rate square plus fixed marker four per second
// - frame counter stages and square wave exported
`timescale 1ns/10ps
module tfs_slot_timer (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst,
   input  wire logic                    i_ce,
   input  wire logic [1:0]              i_mode_cmd,
   input  wire tfs_pkg::tfs_patch_arr_t i_store_patch,
   input  wire tfs_pkg::tfs_scan_tab_t  i_scan_patch,
   output logic                         o_bit_strobe,
   output logic [3:0]                   o_word_bit,
   output logic                         o_sync_a_square,
   output logic                         o_sync_a_marker,
   output logic                         o_sync_b_square,
   output logic                         o_sync_b_marker,
   output logic [3:0]                   o_frame_stage,
   output logic                         o_remote_square,
   output tfs_pkg::tfs_gate_t           o_scan_gate,
   output logic                         o_psr_clear,
   output logic [9:0]                   o_store_read,
   output logic [9:0]                   o_store_write,
   output logic                         o_encode_inhibit
);
   tfs_pkg::tfs_main_st_t q;
   tfs_pkg::tfs_main_st_t d;

   logic                           ph_a;
   logic                           ph_b;
   logic [tfs_pkg::BPW_W-1:0]      bpw;
   logic [tfs_pkg::GRP_W-1:0]      grp;
   logic [tfs_pkg::CHAN_W-1:0]     chan;
   logic [tfs_pkg::FRAME_W-1:0]    frame;
   logic [tfs_pkg::MUX_W-1:0]      mux;
   logic                           bpw_wrap;
   logic                           grp_wrap;
   logic                           chan_wrap;
   logic                           frame_wrap;
   logic                           mux_wrap;
   logic                           master_start;
   tfs_pkg::tfs_slot_t             cur;

   function automatic logic slot_hit(input tfs_pkg::tfs_patch_t p,
                                     input tfs_pkg::tfs_slot_t  s,
                                     input tfs_pkg::tfs_slot_t  c);
      slot_hit = p.en && (s.chan == c.chan) && (s.grp == c.grp) &&
                 (p.frame_any || (s.frame == c.frame)) &&
                 (p.mux_any || (s.mux == c.mux));
   endfunction

   function automatic logic [tfs_pkg::MARK_W-1:0] mark_next(
      input logic [tfs_pkg::MARK_W-1:0] tmr,
      input logic                       start);
      if (start) begin
         mark_next = tfs_pkg::MARK_LOAD;
      end else if (tmr != '0) begin
         mark_next = tmr - 12'h001;
      end else begin
         mark_next = '0;
      end
   endfunction

   tfs_bit_phase u_phase (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .o_ph_a    (ph_a),
      .o_ph_b    (ph_b)
   );

   tfs_mod_cnt #(.W(tfs_pkg::BPW_W), .N(tfs_pkg::BPW_N)) u_bpw (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_step    (ph_b),
      .o_count   (bpw),
      .o_wrap    (bpw_wrap)
   );

   tfs_mod_cnt #(.W(tfs_pkg::GRP_W), .N(tfs_pkg::GRP_N)) u_grp (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_step    (bpw_wrap),
      .o_count   (grp),
      .o_wrap    (grp_wrap)
   );

   tfs_mod_cnt #(.W(tfs_pkg::CHAN_W), .N(tfs_pkg::CHAN_N)) u_chan (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_step    (grp_wrap),
      .o_count   (chan),
      .o_wrap    (chan_wrap)
   );

   tfs_mod_cnt #(.W(tfs_pkg::FRAME_W), .N(tfs_pkg::FRAME_N)) u_frame (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_step    (chan_wrap),
      .o_count   (frame),
      .o_wrap    (frame_wrap)
   );

   tfs_mod_cnt #(.W(tfs_pkg::MUX_W), .N(tfs_pkg::MUX_N)) u_mux (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_step    (chan_wrap),
      .o_count   (mux),
      .o_wrap    (mux_wrap)
   );

   assign cur          = '{frame: frame, mux: mux, chan: chan, grp: grp};
   // both wrap together once per thirty frames: four times a second
   assign master_start = frame_wrap & mux_wrap;

   always_comb begin
      d = q;
      d.mode_s1  = i_mode_cmd;
      d.mode_s2  = q.mode_s1;
      d.patch_s1 = i_store_patch;
      d.patch_s2 = q.patch_s1;
      d.scan_s1  = i_scan_patch;
      d.scan_s2  = q.scan_s1;
      // higher sequence wins if both commands are applied
      if (q.mode_s2[1]) begin
         d.mode = tfs_pkg::TFS_MODE3;
      end else if (q.mode_s2[0]) begin
         d.mode = tfs_pkg::TFS_MODE2;
      end else begin
         d.mode = tfs_pkg::TFS_MODE1;
      end
      d.scan_gate = q.scan_s2[int'(q.mode) * tfs_pkg::N_SCAN
                              + int'(grp) * tfs_pkg::MUX_N
                              + int'(mux)];
      d.bit_strobe  = ph_a;
      d.word_bit    = bpw;
      d.sq_a        = grp[0];
      d.sq_b        = ~grp[0];
      d.frame_stage = frame;
      d.remote_sq   = grp[0];

      d.psr_clear = 1'b0;
      d.rd        = '0;
      d.wr        = '0;
      unique case (q.seq)
         tfs_pkg::TFS_SEQ_IDLE: begin
            if (ph_a && (bpw == tfs_pkg::BPW_SEQ_START)) begin
               d.psr_clear = 1'b1;
               d.seq       = tfs_pkg::TFS_SEQ_READ;
               d.seq_tmr   = tfs_pkg::SEQ_RELOAD;
            end
         end
         tfs_pkg::TFS_SEQ_READ: begin
            if (q.seq_tmr == '0) begin
               for (int i = 0; i < tfs_pkg::N_STORE; i++) begin
                  d.rd[i] = slot_hit(q.patch_s2[i], q.patch_s2[i].rd,
                                     cur);
               end
               d.seq     = tfs_pkg::TFS_SEQ_WRITE;
               d.seq_tmr = tfs_pkg::SEQ_RELOAD;
            end else begin
               d.seq_tmr = q.seq_tmr - 5'h01;
            end
         end
         tfs_pkg::TFS_SEQ_WRITE: begin
            if (q.seq_tmr == '0) begin
               for (int i = 0; i < tfs_pkg::N_STORE; i++) begin
                  d.wr[i] = slot_hit(q.patch_s2[i], q.patch_s2[i].wr,
                                     cur);
               end
               d.seq = tfs_pkg::TFS_SEQ_IDLE;
            end else begin
               d.seq_tmr = q.seq_tmr - 5'h01;
            end
         end
         default: begin
            d.seq = tfs_pkg::TFS_SEQ_IDLE;
         end
      endcase
      // analog words are not loaded while an external word is read
      d.enc_inh = |d.rd;

      d.mark_a_tmr = mark_next(q.mark_a_tmr, master_start);
      d.mark_a     = (d.mark_a_tmr != '0);
      // set B trails by one group slot so the two groups interlace
      d.mark_b_tmr = mark_next(q.mark_b_tmr, q.b_pend && bpw_wrap);
      d.mark_b     = (d.mark_b_tmr != '0);
      if (master_start) begin
         d.b_pend = 1'b1;
      end else if (bpw_wrap) begin
         d.b_pend = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_bit_strobe     = q.bit_strobe;
   assign o_word_bit       = q.word_bit;
   assign o_sync_a_square  = q.sq_a;
   assign o_sync_a_marker  = q.mark_a;
   assign o_sync_b_square  = q.sq_b;
   assign o_sync_b_marker  = q.mark_b;
   assign o_frame_stage    = q.frame_stage;
   assign o_remote_square  = q.remote_sq;
   assign o_scan_gate      = q.scan_gate;
   assign o_psr_clear      = q.psr_clear;
   assign o_store_read     = q.rd;
   assign o_store_write    = q.wr;
   assign o_encode_inhibit = q.enc_inh;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   a_word_bit_step: assert property (ph_b && i_ce |=> bpw != $past(bpw))
      else $error("word-bit count did not step on phase B");
   a_group_step: assert property (bpw_wrap && i_ce
      |=> grp != $past(grp))
      else $error("group did not step on word-bit wrap");
   a_group_hold: assert property (!bpw_wrap && i_ce |=> $stable(grp))
      else $error("group moved without word-bit wrap");
   a_chan_step: assert property (grp_wrap && i_ce |=>
      ($past(chan) == 5'h1D) ? (chan == 5'h00)
                             : (chan == $past(chan) + 5'h01))
      else $error("channel step wrong after group wrap");
   a_frame_mux_step: assert property (chan_wrap && i_ce |=>
      (frame != $past(frame)) && (mux != $past(mux)))
      else $error("frame or mux did not step on channel wrap");
   a_counter_range: assert property (chan < 5'h1E && frame < 4'hA
      && mux < 2'h3)
      else $error("counter left its modulus");
   // gap timer is loaded in the same edge that raises the clear
   a_read_spacing: assert property (q.psr_clear
      |-> q.seq == tfs_pkg::TFS_SEQ_READ
      && q.seq_tmr == tfs_pkg::SEQ_RELOAD)
      else $error("read gap not loaded after clear");
   a_encode_inhibit: assert property (o_encode_inhibit == |o_store_read)
      else $error("encode inhibit disagrees with reads");
   a_mode_default: assert property (q.mode_s2 == 2'h0 && i_ce
      |=> q.mode == tfs_pkg::TFS_MODE1)
      else $error("no command did not select sequence one");
   a_mode_three: assert property (q.mode_s2[1] && i_ce
      |=> q.mode == tfs_pkg::TFS_MODE3)
      else $error("mode three command ignored");
   // set B square is low in reset: valid from the first enabled edge
   a_sync_interlace: assert property (i_ce
      |=> o_sync_b_square != o_sync_a_square)
      else $error("sync squares not in antiphase");
   a_marker_width: assert property ($rose(q.mark_a)
      |-> q.mark_a_tmr == 12'hADC)
      else $error("marker width count wrong");
   a_marker_start: assert property (master_start && i_ce |=> q.mark_a
      && q.b_pend)
      else $error("marker did not start at master frame");
   a_remote_stage: assert property (i_ce
      |=> o_frame_stage == $past(frame))
      else $error("frame stage output lags wrongly");
   a_reset_zero: assert property (@(posedge i_ref_clk) disable iff (1'b0)
      $fell(i_rst) |-> chan == 5'h00 && frame == 4'h0 && mux == 2'h0)
      else $error("counters not zero after reset");

   c_mode_three: cover property (q.mode == tfs_pkg::TFS_MODE3);
   c_marker_a: cover property ($rose(q.mark_a));
   c_marker_b: cover property ($rose(q.mark_b));
   c_store_read: cover property (|q.rd);
endmodule

// file: tb/tfs_far_side.sv
// far-side model: mode command source and remote multiplexer tracker
`timescale 1ns/10ps
module tfs_far_side (
   input  wire logic       i_ref_clk,
   input  wire logic [1:0] i_sel,
   input  wire logic       i_square,
   input  wire logic [3:0] i_frame_stage,
   output logic      [1:0] o_mode_cmd,
   output logic      [7:0] o_frames_seen
);
   logic       sq_q;
   logic [3:0] stage_q;

   initial begin
      o_mode_cmd    = 2'h0;
      o_frames_seen = 8'h00;
      sq_q          = 1'b0;
      stage_q       = 4'h0;
   end

   // command levels move away from the sampling edge
   always @(negedge i_ref_clk) begin
      o_mode_cmd <= i_sel;
   end

   // remote unit latches the frame stages on each square rising edge
   always @(posedge i_ref_clk) begin
      sq_q <= i_square;
      if (i_square && !sq_q) begin
         if (i_frame_stage != stage_q) begin
            o_frames_seen <= o_frames_seen + 8'h01;
         end
         stage_q <= i_frame_stage;
      end
   end
endmodule

// file: tb/tfs_slot_timer_tb.sv
// self-checking bench for the telemetry frame slot timer
`timescale 1ns/10ps
module tfs_slot_timer_tb;
   localparam int WORD_T = 138;
   localparam int RUN_K  = 620;
   localparam int WATCH  = 20 + (RUN_K + 5) * WORD_T + 400;

   logic                    clk;
   logic                    rst;
   logic                    ce;
   logic [1:0]              sel;
   logic [1:0]              mode_cmd;
   tfs_pkg::tfs_patch_arr_t patch;
   tfs_pkg::tfs_scan_tab_t  scan;
   logic                    bit_strobe;
   logic [3:0]              word_bit;
   logic                    sq_a;
   logic                    mk_a;
   logic                    sq_b;
   logic                    mk_b;
   logic [3:0]              frame_stage;
   logic                    remote_sq;
   tfs_pkg::tfs_gate_t      scan_gate;
   logic                    psr_clear;
   logic [9:0]              store_rd;
   logic [9:0]              store_wr;
   logic                    enc_inh;
   logic [7:0]              frames_seen;
   logic [9:0]              exp_rd;
   tfs_pkg::tfs_slot_t      s;
   integer                  mismatches;
   integer                  samples_checked;
   int                      seed;
   int                      t;
   int                      k;
   int                      ph;
   int                      clr_t;
   int                      hold;
   int                      nchg;
   int                      n;
   bit                      clr_seen;
   bit                      froze;

   tfs_slot_timer u_dut (
      .i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_mode_cmd(mode_cmd),
      .i_store_patch(patch), .i_scan_patch(scan),
      .o_bit_strobe(bit_strobe), .o_word_bit(word_bit),
      .o_sync_a_square(sq_a), .o_sync_a_marker(mk_a),
      .o_sync_b_square(sq_b), .o_sync_b_marker(mk_b),
      .o_frame_stage(frame_stage), .o_remote_square(remote_sq),
      .o_scan_gate(scan_gate), .o_psr_clear(psr_clear),
      .o_store_read(store_rd), .o_store_write(store_wr),
      .o_encode_inhibit(enc_inh)
   );

   tfs_far_side u_far (
      .i_ref_clk(clk), .i_sel(sel), .i_square(remote_sq),
      .i_frame_stage(frame_stage), .o_mode_cmd(mode_cmd),
      .o_frames_seen(frames_seen)
   );

   always #50 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got,
                  exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   function automatic tfs_pkg::tfs_slot_t slot_at(input int kk);
      tfs_pkg::tfs_slot_t r;
      r.grp   = 1'((kk / 10) % 2);
      r.chan  = 5'((kk / 20) % 30);
      r.frame = 4'((kk / 600) % 10);
      r.mux   = 2'((kk / 600) % 3);
      return r;
   endfunction

   function automatic logic [9:0] hits(input tfs_pkg::tfs_slot_t c, bit wr);
      logic [9:0]         h;
      tfs_pkg::tfs_slot_t p;
      for (int i = 0; i < 10; i++) begin
         p    = wr ? patch[i].wr : patch[i].rd;
         h[i] = patch[i].en && p.chan == c.chan && p.grp == c.grp
                && (patch[i].frame_any || p.frame == c.frame)
                && (patch[i].mux_any || p.mux == c.mux);
      end
      return h;
   endfunction

   // highest commanded sequence wins, no command means sequence one
   function automatic int mode_of(input logic [1:0] c);
      return c[1] ? 2 : (c[0] ? 1 : 0);
   endfunction

   task automatic setup;
      for (int i = 0; i < 10; i++) begin
         patch[i]           = 27'($random(seed));
         patch[i].en        = 1'b1;
         patch[i].frame_any = 1'b1;
         patch[i].rd.chan   = 5'({$random(seed)} % 30);
         patch[i].wr.chan   = 5'({$random(seed)} % 30);
      end
      // exact frame and mux match, only reachable in the second frame
      patch[0]          = '0;
      patch[0].en       = 1'b1;
      patch[0].rd.frame = 4'h1;
      patch[0].rd.mux   = 2'h1;
      patch[0].wr       = patch[0].rd;
      // disabled entry that would match channel zero, group zero of every frame
      patch[1]          = '0;
      patch[1].frame_any = 1'b1;
      patch[1].mux_any  = 1'b1;
      // last channel, second group
      patch[2].rd.chan  = 5'h1D;
      patch[2].rd.grp   = 1'b1;
      patch[2].mux_any  = 1'b1;
      patch[2].wr       = patch[2].rd;
      scan = 54'({$random(seed), $random(seed)});
   endtask

   initial begin
      #(WATCH * tfs_pkg::CLK_NS);
      mismatches++;
      end_sim();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      sel = 2'h0;
      seed = 32'h429a;
      patch = '0;
      scan = '0;
      mismatches = 0;
      samples_checked = 0;
      // phase B leads after reset: first strobe is already word bit one
      t = WORD_T;
      clr_t = -100;
      clr_seen = 0;
      froze = 0;
      hold = 0;
      nchg = 0;
      n = 0;
      setup();
      repeat (20) @(negedge clk);
      chk({word_bit, frame_stage, bit_strobe, psr_clear, 6'h0}, 16'h0);
      rst = 1'b0;
      @(negedge clk);
      chk({word_bit, frame_stage, 8'h0}, 16'h0);
      chk(16'(store_rd | store_wr), 16'h0);
      $display("test reset done");
      while (bit_strobe !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk(16'(bit_strobe), 16'h1);
      while (t / WORD_T < RUN_K) begin
         @(negedge clk);
         if (ce) begin
            t++;
         end
         k = t / WORD_T;
         ph = t % WORD_T;
         s = slot_at(k);
         chk(16'(bit_strobe), 16'(ph == 0));
         if (ph == 0) begin
            chk(16'(word_bit), 16'(k % 10));
            chk({sq_a, sq_b, remote_sq}, {s.grp, !s.grp, s.grp});
            chk(16'(mk_a | mk_b), 16'h0);
            chk(16'(frame_stage), 16'(s.frame));
            n = mode_of(mode_cmd) * 6 + s.grp * 3 + s.mux;
            chk(16'(scan_gate), 16'(scan[n]));
         end
         if (psr_clear === 1'b1) begin
            chk(16'(k % 10 == 2 && ph <= 3), 16'h1);
            clr_t = t;
            clr_seen = 1;
         end
         if (ph == 10 && k % 10 == 2) begin
            chk(16'(clr_seen), 16'h1);
            clr_seen = 0;
         end
         exp_rd = (t == clr_t + 18) ? hits(s, 1'b0) : 10'h0;
         chk(16'(store_rd), 16'(exp_rd));
         chk(16'(enc_inh), 16'(|exp_rd));
         exp_rd = (t == clr_t + 36) ? hits(s, 1'b1) : 10'h0;
         chk(16'(store_wr), 16'(exp_rd));
         if (ph == 70 && k % 50 == 25) begin
            sel = (nchg < 4) ? 2'(nchg) : 2'($random(seed));
            nchg++;
         end
         // one long stall mid-word: time must stretch, not skip
         if (k == 333 && ph == 60 && !froze) begin
            hold = 200;
            froze = 1;
         end
         if (hold > 0) begin
            chk(16'(word_bit), 16'(k % 10));
            hold--;
         end
         ce = (hold == 0);
      end
      chk(16'(frames_seen), 16'h1);
      $display("test chain done");
      end_sim();
   end
endmodule
